// ---- rtl/slk_pkg.sv ----
// Package: register map, reset values, link states and carriers of the transmit link control
`default_nettype none

package slk_pkg;

    localparam int unsigned ADDR_W = 12;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [11:0] OFS_PLL_LOCK_STATUS  = 12'h56f;
    localparam logic [11:0] OFS_LINK_CONTROL_ONE = 12'h571;
    localparam logic [11:0] OFS_LINK_CONTROL_TWO = 12'h572;
    localparam logic [11:0] OFS_ILAS_DELAY       = 12'h580;
    localparam logic [11:0] OFS_IRQ_STATUS       = 12'h581;
    localparam logic [11:0] OFS_IRQ_MASK         = 12'h582;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned LOCK_NOW_BIT   = 7;
    localparam int unsigned LOCK_LOST_BIT  = 3;
    localparam int unsigned C1_STANDBY_CGS = 7;
    localparam int unsigned C1_TAIL_PN     = 6;
    localparam int unsigned C1_LONG_TEST   = 5;
    localparam int unsigned C1_LANE_SYNC   = 4;
    localparam int unsigned C1_ILAS_HI     = 3;
    localparam int unsigned C1_ILAS_LO     = 2;
    localparam int unsigned C1_FRAME_OFF   = 1;
    localparam int unsigned C1_POWER_DOWN  = 0;
    localparam int unsigned C2_SYNC_HI     = 7;
    localparam int unsigned C2_SYNC_LO     = 6;
    localparam int unsigned C2_SYNC_INV    = 5;
    localparam int unsigned C2_PIN_CMOS    = 4;
    localparam int unsigned C2_BYPASS      = 2;
    localparam int unsigned C2_BIT_INV     = 1;
    localparam int unsigned IRQ_LOCK_LOST  = 0;
    localparam int unsigned IRQ_SYNC_REQ   = 1;

    // ************************************************************
    // Reset values and writable masks
    // ************************************************************
    localparam logic [7:0] RST_CONTROL_ONE = 8'h14;
    localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
    localparam logic [3:0] RST_ILAS_DELAY  = 4'h0;
    localparam logic [7:0] MASK_CONTROL_TWO = 8'hf6;
    localparam logic [1:0] IRQ_W1C_MASK    = 2'h3;

    // ************************************************************
    // Field encodings and counts
    // ************************************************************
    localparam logic [1:0] ILAS_OFF        = 2'h0;
    localparam logic [1:0] ILAS_CONTINUOUS = 2'h3;
    localparam logic [1:0] SYNC_FORCE_CGS  = 2'h2;
    localparam logic [1:0] SYNC_FORCE_DATA = 2'h3;
    localparam logic [3:0] ILAS_MULTIFRAMES = 4'h4;

    typedef enum logic [2:0] {
        SLK_ST_OFF,
        SLK_ST_CGS,
        SLK_ST_WAIT,
        SLK_ST_ILAS,
        SLK_ST_DATA
    } slk_state_t;

    typedef enum logic [2:0] {
        SLK_TX_ZERO,
        SLK_TX_CGS,
        SLK_TX_ILAS,
        SLK_TX_DATA,
        SLK_TX_TEST
    } slk_content_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } slk_reg_req_t;

    typedef struct packed {
        logic       tail_pn_en;
        logic       fac_use_k283;
        logic [1:0] ilas_mode;
        logic       frame_align_char_insert_off;
        logic       sync_pin_cmos;
    } slk_link_cfg_t;

endpackage

`default_nettype wire

// ---- rtl/slk_tx_ctrl.sv ----
// Module: transmit link control registers, link sequencing and symbol conditioning
//
// Strobed register access was decided locally.
`default_nettype none

module slk_tx_ctrl (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire slk_pkg::slk_reg_req_t reg_req,
    output var  logic [7:0]            reg_rdata_q,
    input  wire logic                  pll_locked,
    input  wire logic                  sync_request_in,
    input  wire logic                  lmfc_tick,
    input  wire logic                  standby_req,
    input  wire logic [9:0]            enc_symbol,
    input  wire logic [7:0]            raw_byte,
    output var  logic [9:0]            tx_symbol_q,
    output var  slk_pkg::slk_content_t tx_content_q,
    output var  slk_pkg::slk_link_cfg_t link_cfg_q,
    output var  logic                  link_powerdown_q,
    output var  logic                  irq_q
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0]          ctl1_q;
    logic [7:0]          ctl2_q;
    logic [3:0]          ilas_dly_q;
    logic [1:0]          irq_sts_q;
    logic [1:0]          irq_mask_q;
    logic                pll_lock_q;
    logic                lock_lost_q;
    logic                sync_in_q;
    logic                want_cgs_q;
    logic [3:0]          cnt_q;
    logic [3:0]          cnt_d;
    slk_pkg::slk_state_t state_q;
    slk_pkg::slk_state_t state_d;

    // ************************************************************
    // Register decode
    // ************************************************************
    wire logic hit_status = reg_req.addr == slk_pkg::OFS_PLL_LOCK_STATUS;
    wire logic hit_c1     = reg_req.addr == slk_pkg::OFS_LINK_CONTROL_ONE;
    wire logic hit_c2     = reg_req.addr == slk_pkg::OFS_LINK_CONTROL_TWO;
    wire logic hit_dly    = reg_req.addr == slk_pkg::OFS_ILAS_DELAY;
    wire logic hit_ists   = reg_req.addr == slk_pkg::OFS_IRQ_STATUS;
    wire logic hit_imask  = reg_req.addr == slk_pkg::OFS_IRQ_MASK;
    wire logic wr_c1      = reg_req.wr && hit_c1;
    wire logic wr_ists    = reg_req.wr && hit_ists;

    wire logic [7:0] status_view = {pll_lock_q, 3'h0, lock_lost_q, 3'h0};
    wire logic [7:0] rdata_d =
        hit_status ? status_view :
        hit_c1     ? ctl1_q :
        hit_c2     ? ctl2_q :
        hit_dly    ? {4'h0, ilas_dly_q} :
        hit_ists   ? {6'h0, irq_sts_q} :
        hit_imask  ? {6'h0, irq_mask_q} : 8'h00;

    // ************************************************************
    // Events
    // ************************************************************
    wire logic lock_drop   = pll_lock_q && !pll_locked;
    wire logic lol_clear   = wr_c1 && reg_req.wdata[slk_pkg::C1_POWER_DOWN];
    wire logic powered_dn  = ctl1_q[slk_pkg::C1_POWER_DOWN];
    // Pin is active low; the invert bit flips its sense
    wire logic sync_assert = ctl2_q[slk_pkg::C2_SYNC_INV] ? sync_in_q : !sync_in_q;
    wire logic [1:0] sync_ctl = ctl2_q[slk_pkg::C2_SYNC_HI:slk_pkg::C2_SYNC_LO];
    wire logic want_cgs_d = (sync_ctl == slk_pkg::SYNC_FORCE_CGS)  ? 1'b1 :
                            (sync_ctl == slk_pkg::SYNC_FORCE_DATA) ? 1'b0 :
                            sync_assert;
    wire logic sync_rise  = want_cgs_d && !want_cgs_q && !powered_dn;
    wire logic [1:0] irq_events = {sync_rise, lock_drop};
    wire logic [1:0] ilas_mode = ctl1_q[slk_pkg::C1_ILAS_HI:slk_pkg::C1_ILAS_LO];

    // ************************************************************
    // Register writes and sticky flags
    // ************************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctl1_q     <= slk_pkg::RST_CONTROL_ONE;
            ctl2_q     <= slk_pkg::RST_CONTROL_TWO;
            ilas_dly_q <= slk_pkg::RST_ILAS_DELAY;
            irq_mask_q <= 2'h0;
        end else if (reg_req.wr) begin
            if (hit_c1) ctl1_q <= reg_req.wdata;
            if (hit_c2) ctl2_q <= reg_req.wdata & slk_pkg::MASK_CONTROL_TWO;
            if (hit_dly) ilas_dly_q <= reg_req.wdata[3:0];
            if (hit_imask) irq_mask_q <= reg_req.wdata[1:0];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pll_lock_q  <= 1'b0;
            lock_lost_q <= 1'b0;
            irq_sts_q   <= 2'h0;
            irq_q       <= 1'b0;
            sync_in_q   <= 1'b1;
            want_cgs_q  <= 1'b0;
            reg_rdata_q <= 8'h00;
        end else begin
            pll_lock_q  <= pll_locked;
            lock_lost_q <= lock_drop || (lock_lost_q && !lol_clear);
            irq_sts_q   <= irq_events |
                           (irq_sts_q & ~(wr_ists ? reg_req.wdata[1:0] & slk_pkg::IRQ_W1C_MASK
                                                  : 2'h0));
            irq_q       <= |(irq_sts_q & irq_mask_q);
            sync_in_q   <= sync_request_in;
            want_cgs_q  <= want_cgs_d;
            reg_rdata_q <= reg_req.rd ? rdata_d : 8'h00;
        end
    end

    // ************************************************************
    // Link sequencer
    // ************************************************************
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (powered_dn) begin
            state_d = slk_pkg::SLK_ST_OFF;
        end else begin
            unique case (state_q)
                slk_pkg::SLK_ST_OFF: begin
                    state_d = slk_pkg::SLK_ST_CGS;
                end
                slk_pkg::SLK_ST_CGS: begin
                    if (!want_cgs_q) begin
                        state_d = (ilas_mode == slk_pkg::ILAS_OFF) ? slk_pkg::SLK_ST_DATA
                                                                   : slk_pkg::SLK_ST_WAIT;
                        cnt_d   = ilas_dly_q;
                    end
                end
                slk_pkg::SLK_ST_WAIT: begin
                    if (want_cgs_q) begin
                        state_d = slk_pkg::SLK_ST_CGS;
                    end else if (lmfc_tick) begin
                        if (cnt_q == 4'h0) begin
                            state_d = slk_pkg::SLK_ST_ILAS;
                            cnt_d   = slk_pkg::ILAS_MULTIFRAMES - 4'h1;
                        end else begin
                            cnt_d = cnt_q - 4'h1;
                        end
                    end
                end
                slk_pkg::SLK_ST_ILAS: begin
                    if (want_cgs_q) begin
                        state_d = slk_pkg::SLK_ST_CGS;
                    end else if (lmfc_tick && ilas_mode != slk_pkg::ILAS_CONTINUOUS) begin
                        if (cnt_q == 4'h0) state_d = slk_pkg::SLK_ST_DATA;
                        else cnt_d = cnt_q - 4'h1;
                    end
                end
                slk_pkg::SLK_ST_DATA: begin
                    if (want_cgs_q) state_d = slk_pkg::SLK_ST_CGS;
                end
                default: begin
                    state_d = slk_pkg::SLK_ST_OFF;
                end
            endcase
        end
    end

    // Lane content; the wait for the boundary keeps sending K28.5
    wire slk_pkg::slk_content_t run_content =
        (state_q == slk_pkg::SLK_ST_ILAS) ? slk_pkg::SLK_TX_ILAS :
        (state_q == slk_pkg::SLK_ST_DATA) ?
            (ctl1_q[slk_pkg::C1_LONG_TEST] ? slk_pkg::SLK_TX_TEST : slk_pkg::SLK_TX_DATA) :
        slk_pkg::SLK_TX_CGS;
    wire slk_pkg::slk_content_t content_d =
        (state_q == slk_pkg::SLK_ST_OFF) ? slk_pkg::SLK_TX_ZERO :
        standby_req ? (ctl1_q[slk_pkg::C1_STANDBY_CGS] ? slk_pkg::SLK_TX_CGS
                                                       : slk_pkg::SLK_TX_ZERO) :
        run_content;

    // ************************************************************
    // Symbol conditioning
    // ************************************************************
    wire logic [9:0] sym_pre = ctl2_q[slk_pkg::C2_BYPASS] ? {2'h0, raw_byte} : enc_symbol;
    wire logic [9:0] sym_d   = ctl2_q[slk_pkg::C2_BIT_INV] ? ~sym_pre : sym_pre;
    wire logic       gated   = state_q == slk_pkg::SLK_ST_OFF;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q          <= slk_pkg::SLK_ST_OFF;
            cnt_q            <= 4'h0;
            tx_content_q     <= slk_pkg::SLK_TX_ZERO;
            tx_symbol_q      <= 10'h000;
            link_powerdown_q <= 1'b0;
            link_cfg_q       <= '0;
        end else begin
            state_q          <= state_d;
            cnt_q            <= cnt_d;
            tx_content_q     <= content_d;
            tx_symbol_q      <= gated ? 10'h000 : sym_d;
            link_powerdown_q <= powered_dn;
            link_cfg_q.tail_pn_en   <= ctl1_q[slk_pkg::C1_TAIL_PN];
            link_cfg_q.fac_use_k283 <= ctl1_q[slk_pkg::C1_LANE_SYNC];
            link_cfg_q.ilas_mode    <= ilas_mode;
            link_cfg_q.frame_align_char_insert_off <= ctl1_q[slk_pkg::C1_FRAME_OFF];
            link_cfg_q.sync_pin_cmos <= ctl2_q[slk_pkg::C2_PIN_CMOS];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_lock_lost_sets;
        @(posedge clk_sys) disable iff (!resetn)
        (pll_lock_q && !pll_locked) |=> lock_lost_q ##1 lock_lost_q;
    endproperty
    a_lock_lost_sets: assert property (p_lock_lost_sets) else $error("lock loss not latched");

    property p_lock_lost_clear;
        @(posedge clk_sys) disable iff (!resetn)
        (lol_clear && !lock_drop) |=> !lock_lost_q;
    endproperty
    a_lock_lost_clear: assert property (p_lock_lost_clear) else $error("lock loss not cleared");

    property p_standby_zero;
        @(posedge clk_sys) disable iff (!resetn)
        (standby_req && !ctl1_q[slk_pkg::C1_STANDBY_CGS]) |=> tx_content_q == slk_pkg::SLK_TX_ZERO;
    endproperty
    a_standby_zero: assert property (p_standby_zero) else $error("standby not zero");

    property p_long_test;
        @(posedge clk_sys) disable iff (!resetn)
        (state_q == slk_pkg::SLK_ST_DATA && !standby_req && ctl1_q[slk_pkg::C1_LONG_TEST])
            |=> tx_content_q == slk_pkg::SLK_TX_TEST;
    endproperty
    a_long_test: assert property (p_long_test) else $error("test samples missing");

    property p_power_down;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(powered_dn) |=> state_q == slk_pkg::SLK_ST_OFF ##1
            (tx_content_q == slk_pkg::SLK_TX_ZERO && tx_symbol_q == 10'h000 && link_powerdown_q);
    endproperty
    a_power_down: assert property (p_power_down) else $error("link not powered down");

    property p_force_cgs;
        @(posedge clk_sys) disable iff (!resetn)
        (sync_ctl == slk_pkg::SYNC_FORCE_CGS && !powered_dn && !standby_req)[*4]
            |-> tx_content_q == slk_pkg::SLK_TX_CGS;
    endproperty
    a_force_cgs: assert property (p_force_cgs) else $error("forced K28.5 missing");

    property p_ilas_boundary;
        @(posedge clk_sys) disable iff (!resetn)
        (state_q == slk_pkg::SLK_ST_WAIT && lmfc_tick && cnt_q == 4'h0 && !want_cgs_q
            && !powered_dn) |=> state_q == slk_pkg::SLK_ST_ILAS;
    endproperty
    a_ilas_boundary: assert property (p_ilas_boundary) else $error("alignment late");

    property p_bypass_msb;
        @(posedge clk_sys) disable iff (!resetn)
        (ctl2_q[slk_pkg::C2_BYPASS] && !ctl2_q[slk_pkg::C2_BIT_INV] && !gated)
            |=> tx_symbol_q == {2'h0, $past(raw_byte)};
    endproperty
    a_bypass_msb: assert property (p_bypass_msb) else $error("bypass symbol wrong");

    property p_bit_invert;
        @(posedge clk_sys) disable iff (!resetn)
        (ctl2_q[slk_pkg::C2_BIT_INV] && !ctl2_q[slk_pkg::C2_BYPASS] && !gated)
            |=> tx_symbol_q == ~$past(enc_symbol);
    endproperty
    a_bit_invert: assert property (p_bit_invert) else $error("symbol not inverted");

    property p_irq_level;
        @(posedge clk_sys) disable iff (!resetn)
        (|(irq_sts_q & irq_mask_q)) |=> irq_q;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

endmodule // slk_tx_ctrl

`default_nettype wire

// ---- bench/slk_rx_model.sv ----
// Partner model: link receiver that drives the sync request back to the transmitter
`default_nettype none

module slk_rx_model (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire slk_pkg::slk_content_t tx_content_q,
    input  wire logic                  resync,
    input  wire logic [3:0]            cgs_need,
    output var  logic                  sync_request_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cgs_cnt_q;

    // Request is active low; held until enough K28.5 cycles seen, then released
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync_request_in <= 1'b0;
            cgs_cnt_q       <= 4'h0;
        end else if (resync) begin
            sync_request_in <= 1'b0;
            cgs_cnt_q       <= 4'h0;
        end else if (!sync_request_in && tx_content_q == slk_pkg::SLK_TX_CGS) begin
            cgs_cnt_q <= cgs_cnt_q + 4'h1;
            if (cgs_cnt_q >= cgs_need) begin
                sync_request_in <= 1'b1;
            end
        end
    end
endmodule // slk_rx_model

`default_nettype wire

// ---- bench/serial_link_transmit_control_bench.sv ----
// Testbench: register, lock, interrupt, link sequencing and symbol checks
`default_nettype none

module serial_link_transmit_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk_sys = 1'b0;
    logic                   resetn = 1'b0;
    slk_pkg::slk_reg_req_t  reg_req = '0;
    logic [7:0]             reg_rdata_q;
    logic                   pll_locked = 1'b1;
    logic                   sync_request_in;
    logic                   lmfc_tick = 1'b0;
    logic                   standby_req = 1'b0;
    logic                   resync = 1'b0;
    logic [9:0]             enc_symbol = 10'h000;
    logic [7:0]             raw_byte = 8'h00;
    logic [9:0]             tx_symbol_q;
    slk_pkg::slk_content_t  tx_content_q;
    slk_pkg::slk_link_cfg_t link_cfg_q;
    logic                   link_powerdown_q;
    logic                   irq_q;
    logic [3:0]             tick_cnt = 4'h0;
    logic [7:0]             rd_v;
    logic [7:0]             r1;
    logic [7:0]             r2;
    int                     num_errors = 0;
    int                     comparisons = 0;

    slk_tx_ctrl u_slk_tx_ctrl (
        .clk_sys(clk_sys), .resetn(resetn), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
        .pll_locked(pll_locked), .sync_request_in(sync_request_in), .lmfc_tick(lmfc_tick),
        .standby_req(standby_req), .enc_symbol(enc_symbol), .raw_byte(raw_byte),
        .tx_symbol_q(tx_symbol_q), .tx_content_q(tx_content_q), .link_cfg_q(link_cfg_q),
        .link_powerdown_q(link_powerdown_q), .irq_q(irq_q)
    );

    slk_rx_model u_slk_rx_model (
        .clk_sys(clk_sys), .resetn(resetn), .tx_content_q(tx_content_q),
        .resync(resync), .cgs_need(4'h4), .sync_request_in(sync_request_in)
    );

    always #12.5 clk_sys = ~clk_sys;

    // Multiframe boundary every 16 cycles
    always @(posedge clk_sys) begin
        tick_cnt  <= tick_cnt + 4'h1;
        lmfc_tick <= (tick_cnt == 4'hf);
    end

    // ************************************************************
    // Compare and closing tasks
    // ************************************************************
    task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_word(input string what, input logic [9:0] e, input logic [9:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_content(input string what, input slk_pkg::slk_content_t e);
        comparisons++;
        if (tx_content_q !== e) begin
            num_errors++;
            $display("Error %s expected %0d seen %0d", what, e, tx_content_q);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Bus and link tasks; each starts and ends just after a rising edge
    // ************************************************************
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        #1 d = reg_rdata_q;
        @(posedge clk_sys);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        reg_rd(a, rd_v);
        check_byte("register", e, rd_v);
    endtask

    task automatic wait_content(input slk_pkg::slk_content_t e, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk_sys);
            #1;
            if (tx_content_q === e) break;
        end
        check_content("content", e);
        @(posedge clk_sys);
    endtask

    task automatic pulse_resync();
        resync <= 1'b1;
        @(posedge clk_sys);
        resync <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic sym_case(input logic [7:0] c2);
        logic [9:0] e;
        enc_symbol <= 10'($urandom);
        raw_byte   <= 8'($urandom);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_TWO, c2);
        repeat (2) @(posedge clk_sys);
        e = c2[2] ? {2'b00, raw_byte} : enc_symbol;
        if (c2[1]) e = ~e;
        #1 check_word("symbol", e, tx_symbol_q);
        @(posedge clk_sys);
    endtask

    task automatic check_irq(input logic e);
        repeat (2) @(posedge clk_sys);
        #1 check_byte("irq", {7'h00, e}, {7'h00, irq_q});
        @(posedge clk_sys);
    endtask

    initial begin
        #(25ns * 20000);
        num_errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(81680));
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rd_chk(slk_pkg::OFS_LINK_CONTROL_ONE, 8'h14);
        rd_chk(slk_pkg::OFS_LINK_CONTROL_TWO, 8'h00);
        rd_chk(12'h123, 8'h00);
        wait_content(slk_pkg::SLK_TX_CGS, 20);
        wait_content(slk_pkg::SLK_TX_ILAS, 60);
        wait_content(slk_pkg::SLK_TX_DATA, 120);
        sym_case(8'h00);
        sym_case(8'h04);
        sym_case(8'h02);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_TWO, 8'h00);
        // Lock loss, interrupt and power-down
        pll_locked <= 1'b0;
        repeat (3) @(posedge clk_sys);
        pll_locked <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_chk(slk_pkg::OFS_PLL_LOCK_STATUS, 8'h88);
        reg_wr(slk_pkg::OFS_IRQ_MASK, 8'h01);
        check_irq(1'b1);
        reg_wr(slk_pkg::OFS_IRQ_MASK, 8'h00);
        check_irq(1'b0);
        reg_wr(slk_pkg::OFS_IRQ_MASK, 8'h01);
        reg_wr(slk_pkg::OFS_IRQ_STATUS, 8'h01);
        check_irq(1'b0);
        rd_chk(slk_pkg::OFS_IRQ_STATUS, 8'h02);
        reg_wr(slk_pkg::OFS_IRQ_STATUS, 8'h02);
        rd_chk(slk_pkg::OFS_IRQ_STATUS, 8'h00);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_ONE, 8'h15);
        rd_chk(slk_pkg::OFS_PLL_LOCK_STATUS, 8'h80);
        check_byte("powerdown", 8'h01, {7'h00, link_powerdown_q});
        check_word("symbol off", 10'h000, tx_symbol_q);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_ONE, 8'h14);
        pulse_resync();
        wait_content(slk_pkg::SLK_TX_CGS, 20);
        // Alignment modes
        reg_wr(slk_pkg::OFS_LINK_CONTROL_ONE, 8'h1c);
        pulse_resync();
        wait_content(slk_pkg::SLK_TX_ILAS, 100);
        repeat (80) @(posedge clk_sys);
        wait_content(slk_pkg::SLK_TX_ILAS, 1);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_ONE, 8'h10);
        pulse_resync();
        wait_content(slk_pkg::SLK_TX_CGS, 20);
        wait_content(slk_pkg::SLK_TX_DATA, 12);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_ONE, 8'h14);
        // Sync input control and inversion
        reg_wr(slk_pkg::OFS_LINK_CONTROL_TWO, 8'h80);
        wait_content(slk_pkg::SLK_TX_CGS, 10);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_TWO, 8'hc0);
        wait_content(slk_pkg::SLK_TX_DATA, 120);
        // A fresh request while forced to data must be ignored
        pulse_resync();
        repeat (4) @(posedge clk_sys);
        wait_content(slk_pkg::SLK_TX_DATA, 1);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_TWO, 8'h00);
        wait_content(slk_pkg::SLK_TX_CGS, 10);
        wait_content(slk_pkg::SLK_TX_DATA, 120);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_TWO, 8'h20);
        wait_content(slk_pkg::SLK_TX_CGS, 10);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_TWO, 8'h00);
        wait_content(slk_pkg::SLK_TX_DATA, 120);
        // Standby and long transport test
        standby_req <= 1'b1;
        wait_content(slk_pkg::SLK_TX_ZERO, 6);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_ONE, 8'h94);
        wait_content(slk_pkg::SLK_TX_CGS, 6);
        standby_req <= 1'b0;
        reg_wr(slk_pkg::OFS_LINK_CONTROL_ONE, 8'h34);
        wait_content(slk_pkg::SLK_TX_TEST, 6);
        // Random configuration read-back and refused writes
        for (int i = 0; i < 4; i++) begin
            r1 = 8'($urandom) & 8'hfe;
            r2 = 8'($urandom) & 8'h36;
            reg_wr(slk_pkg::OFS_LINK_CONTROL_ONE, r1);
            reg_wr(slk_pkg::OFS_LINK_CONTROL_TWO, r2);
            rd_chk(slk_pkg::OFS_LINK_CONTROL_ONE, r1);
            rd_chk(slk_pkg::OFS_LINK_CONTROL_TWO, r2);
            check_word("cfg", {4'h0, r1[6], r1[4], r1[3:2], r1[1], r2[4]}, link_cfg_q);
        end
        reg_wr(slk_pkg::OFS_ILAS_DELAY, 8'h0a);
        rd_chk(slk_pkg::OFS_ILAS_DELAY, 8'h0a);
        reg_wr(slk_pkg::OFS_LINK_CONTROL_TWO, 8'hff);
        rd_chk(slk_pkg::OFS_LINK_CONTROL_TWO, 8'hf6);
        reg_wr(slk_pkg::OFS_PLL_LOCK_STATUS, 8'hff);
        rd_chk(slk_pkg::OFS_PLL_LOCK_STATUS, 8'h80);
        end_of_test();
    end
endmodule // serial_link_transmit_control_bench

`default_nettype wire
